// file: hdl/mmfc_pkg.sv
// Purpose: Shared constants and types of the multi-mode frequency counter.
// Assumes: 100 MHz mclk; registers reached over APB with 32-bit data.
// Notes: Every offset, field position, reset value and timing count lives here.
`default_nettype none

package mmfc_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_GATE = 8'h08;
	localparam logic [7:0] OFS_SPAN = 8'h0c;
	localparam logic [7:0] OFS_RESULT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CMD_CLR_BIT = 0;
	localparam int STAT_NEW_BIT = 0;
	localparam int STAT_APPROX_BIT = 1;
	localparam int STAT_DIR_BIT = 2;
	localparam int STAT_RANGE_BIT = 3;

	// ==========================================================
	// Counter modes
	typedef enum logic [2:0]
	{
		MD_OFF = 3'h0,
		MD_FREQ_GATE = 3'h1,
		MD_FREQ_CYC = 3'h2,
		MD_DUTY = 3'h3,
		MD_WIDTH = 3'h4,
		MD_PERIOD = 3'h5,
		MD_EVENT = 3'h6,
		MD_QUAD = 3'h7
	} mmfc_mode_t;

	// Divider sequencer states, Gray coded along idle, run, done.
	typedef enum logic [1:0]
	{
		DV_IDLE = 2'h0,
		DV_RUN = 2'h1,
		DV_DONE = 2'h3
	} mmfc_div_t;

	// ==========================================================
	// Reset values and limits
	localparam mmfc_mode_t MODE_RST = MD_OFF;
	localparam logic [31:0] GATE_RST = 32'h000186a0;
	localparam logic [31:0] SPAN_RST = 32'h00002710;
	localparam logic [31:0] APPROX_SPAN = 32'h0000ea60;
	localparam logic [31:0] EVENT_MAX = 32'h03d09000;
	localparam int MIN_FREQ_HZ = 48;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int US_NS = 1000;
	localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LATENCY_MAX_MS = 43;
	localparam int LATENCY_MAX_CYC = (LATENCY_MAX_MS * 1000000) / CLK_PERIOD_NS;
	localparam logic [6:0] US_LAST = 7'(US_CYC - 1);

	// Arithmetic constants for the shared divider.
	localparam int DIV_STEPS = 48;
	localparam logic [5:0] DIV_LAST = 6'(DIV_STEPS - 1);
	localparam logic [47:0] US_PER_S = 48'h0000000f4240;
	localparam logic [47:0] CLK_HZ_W = 48'(CLK_HZ);
	localparam logic [47:0] PCT = 48'h000000000064;

endpackage

`default_nettype wire

// file: hdl/mmfc_edge_if.sv
// Purpose: Carries synchronised levels and edge pulses of the two channels.
// Assumes: One mclk domain on both ends.
// Notes: Index 0 is the counted channel, index 1 the direction channel.
`default_nettype none

interface mmfc_edge_if;
	logic [1:0] lvl;
	logic [1:0] rise;
	logic [1:0] fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface

`default_nettype wire

// file: hdl/mmfc_sync_edge.sv
// Purpose: Brings both threshold-crossing inputs into mclk and finds their edges.
// Assumes: Inputs are asynchronous comparator outputs.
// Notes: Edges appear two cycles after the pin changes.
`default_nettype none

module mmfc_sync_edge (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Asynchronous crossing inputs
	input wire logic [1:0] cross_in,
	// Synchronised events
	mmfc_edge_if.src ev
);

	logic [1:0] meta_r;
	logic [1:0] sync_r;
	logic [1:0] prev_r;

	// ==========================================================
	// Per-channel synchroniser and edge detector
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		// Two stages, then a history stage for edge detection.
		always_ff @(posedge mclk)
		begin
			if (rst)
			begin
				meta_r[i] <= 1'b0;
				sync_r[i] <= 1'b0;
				prev_r[i] <= 1'b0;
			end
			else
			begin
				meta_r[i] <= cross_in[i]; // R12
				sync_r[i] <= meta_r[i]; // R12
				prev_r[i] <= sync_r[i];
			end
		end

		// Only the second stage and its history are looked at.
		assign ev.lvl[i] = sync_r[i];
		assign ev.rise[i] = sync_r[i] & ~prev_r[i]; // R01
		assign ev.fall[i] = ~sync_r[i] & prev_r[i]; // R01
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_sync_delay: assert property (!rst && !$past(rst, 3) && $rose(sync_r[0]) |-> $past(cross_in[0], 2)) // R12
		else $error("Synchronised level did not follow the pin after two stages.");
	a_rise_single: assert property (ev.rise[0] |=> !ev.rise[0]) // R01
		else $error("Rising edge pulse lasted more than one cycle.");

endmodule

`default_nettype wire

// file: hdl/mmfc_top.sv
// Purpose: Multi-mode counter on a threshold-crossing channel, with an APB register file.
// Assumes: cross_in[0] counts, cross_in[1] gives quadrature direction; mclk at 100 MHz.
// Notes on behaviour
// R01: Only transitions of the crossing input through the threshold are counted.
// R02: Gated frequency counts rising edges over the gate, then publishes the average.
// R03: Cycle frequency divides the clock rate by one period, updated each period.
// R04: A cycle measurement never waits longer than 43 ms for its result.
// R05: Duty mode reports high time as a percentage of the period.
// R06: Pulse width mode reports microseconds the input stays high.
// R07: Period mode reports microseconds between successive rising edges.
// R08: Event mode counts rising edges since clearing, up to 64000000.
// R09: A span above 60000 marks the event count approximate.
// R10: Quadrature counts up or down by the direction channel's phase.
// R11: Reselecting a mode or a reset command clears the count to zero.
// R12: The crossing inputs pass a two-stage synchroniser before edge detection.
`default_nettype none

module mmfc_top #(
	parameter int unsigned LATENCY_MAX_CYC = mmfc_pkg::LATENCY_MAX_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Threshold crossing inputs
	input wire logic [1:0] cross_in
);

	// ==========================================================
	// Declarations
	mmfc_edge_if ev ();
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r, rd_mux;
	logic xfer, wr, rd_setup, clr_req;
	mmfc_pkg::mmfc_mode_t mode_r;
	logic [31:0] gate_r, span_r, gate_eff;
	logic [6:0] us_cnt_r;
	logic us_tick;
	logic [31:0] gate_cnt_r, edge_cnt_r;
	logic gate_end;
	logic armed_r, timeout;
	logic [31:0] per_cyc_r, hi_cyc_r, per_us_r, hi_us_r;
	logic [31:0] evt_cnt_r, result_r;
	logic new_r, approx_r, dir_r, range_r;
	logic pub_direct, pub_range, div_go, evt_chg;
	logic [31:0] pub_val;
	logic [47:0] div_num;
	logic [31:0] div_den;
	mmfc_pkg::mmfc_div_t div_st;
	logic [47:0] num_sh_r;
	logic [31:0] den_r, rem_r, div_sat;
	logic [5:0] step_r;
	logic [32:0] rem_t;
	logic div_ge;
	logic rise, fall, lvl;

	// Legal register offsets.
	function automatic logic addr_ok(input logic [7:0] a);
		return (a == mmfc_pkg::OFS_CTRL) || (a == mmfc_pkg::OFS_CMD) || (a == mmfc_pkg::OFS_GATE) ||
			(a == mmfc_pkg::OFS_SPAN) || (a == mmfc_pkg::OFS_RESULT) || (a == mmfc_pkg::OFS_STATUS);
	endfunction

	// Input synchroniser and edge finder.
	mmfc_sync_edge u_sync (
		.mclk(mclk),
		.rst(rst),
		.cross_in(cross_in),
		.ev(ev)
	);

	// Counted channel events.
	assign rise = ev.rise[0];
	assign fall = ev.fall[0];
	assign lvl = ev.lvl[0];

	// ==========================================================
	// APB slave: one wait state, data loaded in the first access cycle
	assign xfer = psel & penable & pready_r;
	assign wr = xfer & pwrite;
	assign rd_setup = psel & penable & ~pready_r;
	assign clr_req = wr & ((paddr == mmfc_pkg::OFS_CTRL) || // R11
		((paddr == mmfc_pkg::OFS_CMD) && pwdata[mmfc_pkg::CMD_CLR_BIT])); // R11

	// Read multiplexer.
	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (paddr)
			mmfc_pkg::OFS_CTRL: rd_mux = {29'h0, mode_r};
			mmfc_pkg::OFS_GATE: rd_mux = gate_r;
			mmfc_pkg::OFS_SPAN: rd_mux = span_r;
			mmfc_pkg::OFS_RESULT: rd_mux = ((mode_r == mmfc_pkg::MD_EVENT) || (mode_r == mmfc_pkg::MD_QUAD)) ?
				evt_cnt_r : result_r;
			mmfc_pkg::OFS_STATUS:
			begin
				rd_mux[mmfc_pkg::STAT_NEW_BIT] = new_r;
				rd_mux[mmfc_pkg::STAT_APPROX_BIT] = approx_r;
				rd_mux[mmfc_pkg::STAT_DIR_BIT] = dir_r;
				rd_mux[mmfc_pkg::STAT_RANGE_BIT] = range_r;
			end
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Handshake, read data and error answer.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			pready_r <= rd_setup;
			pslverr_r <= rd_setup & ~addr_ok(paddr);
			if (rd_setup)
			begin
				prdata_r <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

	// Configuration registers.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mode_r <= mmfc_pkg::MODE_RST;
			gate_r <= mmfc_pkg::GATE_RST;
			span_r <= mmfc_pkg::SPAN_RST;
		end
		else if (wr)
		begin
			if (paddr == mmfc_pkg::OFS_CTRL)
				mode_r <= mmfc_pkg::mmfc_mode_t'(pwdata[mmfc_pkg::CTRL_MODE_LSB +: 3]);
			if (paddr == mmfc_pkg::OFS_GATE)
				gate_r <= pwdata;
			if (paddr == mmfc_pkg::OFS_SPAN)
				span_r <= pwdata;
		end
	end

	// Approximate marker follows the configured span.
	always_ff @(posedge mclk)
	begin
		if (rst)
			approx_r <= 1'b0;
		else
			approx_r <= (span_r > mmfc_pkg::APPROX_SPAN); // R09
	end

	// ==========================================================
	// Microsecond tick divider
	always_ff @(posedge mclk)
	begin
		if (rst || us_tick)
			us_cnt_r <= 7'h00;
		else
			us_cnt_r <= us_cnt_r + 7'h01;
	end

	assign us_tick = (us_cnt_r == mmfc_pkg::US_LAST);

	// ==========================================================
	// Gated frequency: edges over a gate measured in microseconds
	assign gate_eff = (gate_r == 32'h00000000) ? 32'h00000001 : gate_r;
	assign gate_end = (mode_r == mmfc_pkg::MD_FREQ_GATE) && us_tick && (gate_cnt_r >= gate_eff - 32'h00000001);

	// Gate timer and edge tally restart at every gate end.
	always_ff @(posedge mclk)
	begin
		if (rst || clr_req || (mode_r != mmfc_pkg::MD_FREQ_GATE) || gate_end)
		begin
			gate_cnt_r <= 32'h00000000;
			edge_cnt_r <= 32'h00000000;
		end
		else
		begin
			gate_cnt_r <= gate_cnt_r + {31'h0, us_tick}; // R02
			edge_cnt_r <= edge_cnt_r + {31'h0, rise}; // R02
		end
	end

	// ==========================================================
	// Period and high-time counters, restarted at each rising edge
	assign timeout = armed_r && (per_cyc_r >= LATENCY_MAX_CYC) &&
		((mode_r == mmfc_pkg::MD_FREQ_CYC) || (mode_r == mmfc_pkg::MD_DUTY)); // R04

	always_ff @(posedge mclk)
	begin
		if (rst || clr_req)
		begin
			armed_r <= 1'b0;
			per_cyc_r <= 32'h00000000;
			hi_cyc_r <= 32'h00000000;
			per_us_r <= 32'h00000000;
			hi_us_r <= 32'h00000000;
		end
		else if (rise)
		begin
			armed_r <= 1'b1;
			per_cyc_r <= 32'h00000001;
			hi_cyc_r <= 32'h00000001;
			per_us_r <= 32'h00000000;
			hi_us_r <= 32'h00000000;
		end
		else if (timeout)
			armed_r <= 1'b0; // R04
		else
		begin
			per_cyc_r <= per_cyc_r + {31'h0, (per_cyc_r != 32'hffffffff)};
			hi_cyc_r <= hi_cyc_r + {31'h0, lvl && (hi_cyc_r != 32'hffffffff)}; // R05
			per_us_r <= per_us_r + {31'h0, us_tick}; // R07
			hi_us_r <= hi_us_r + {31'h0, us_tick && lvl}; // R06
		end
	end

	// ==========================================================
	// Result selection per mode
	always_comb
	begin
		pub_direct = 1'b0;
		pub_range = 1'b0;
		pub_val = 32'h00000000;
		div_go = 1'b0;
		div_num = 48'h0;
		div_den = 32'h00000001;
		if (timeout)
		begin
			pub_direct = 1'b1;
			pub_range = 1'b1;
		end
		else
		begin
			unique case (mode_r)
				mmfc_pkg::MD_FREQ_GATE:
				begin
					div_go = gate_end; // R02
					div_num = 48'(edge_cnt_r + {31'h0, rise}) * mmfc_pkg::US_PER_S;
					div_den = gate_eff;
				end
				mmfc_pkg::MD_FREQ_CYC:
				begin
					div_go = rise && armed_r; // R03
					div_num = mmfc_pkg::CLK_HZ_W;
					div_den = per_cyc_r;
				end
				mmfc_pkg::MD_DUTY:
				begin
					div_go = rise && armed_r; // R05
					div_num = 48'(hi_cyc_r) * mmfc_pkg::PCT;
					div_den = per_cyc_r;
				end
				mmfc_pkg::MD_WIDTH:
				begin
					pub_direct = fall && armed_r; // R06
					pub_val = hi_us_r;
				end
				mmfc_pkg::MD_PERIOD:
				begin
					pub_direct = rise && armed_r; // R07
					pub_val = per_us_r;
				end
				mmfc_pkg::MD_OFF, mmfc_pkg::MD_EVENT, mmfc_pkg::MD_QUAD:
				begin
					pub_direct = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Shared restoring divider, one quotient bit per cycle
	assign rem_t = {rem_r, num_sh_r[47]};
	assign div_ge = (rem_t >= {1'b0, den_r});
	assign div_sat = (|num_sh_r[47:32]) ? 32'hffffffff : num_sh_r[31:0];

	// A request that meets a busy divider is dropped; the next period brings another.
	always_ff @(posedge mclk)
	begin
		if (rst || clr_req)
		begin
			div_st <= mmfc_pkg::DV_IDLE;
			num_sh_r <= 48'h0;
			den_r <= 32'h00000001;
			rem_r <= 32'h00000000;
			step_r <= 6'h00;
		end
		else
		begin
			unique case (div_st)
				mmfc_pkg::DV_IDLE:
				begin
					if (div_go)
					begin
						div_st <= mmfc_pkg::DV_RUN;
						num_sh_r <= div_num;
						den_r <= div_den;
						rem_r <= 32'h00000000;
						step_r <= 6'h00;
					end
				end
				mmfc_pkg::DV_RUN:
				begin
					rem_r <= div_ge ? 32'(rem_t - {1'b0, den_r}) : rem_t[31:0];
					num_sh_r <= {num_sh_r[46:0], div_ge};
					step_r <= step_r + 6'h01;
					if (step_r == mmfc_pkg::DIV_LAST)
						div_st <= mmfc_pkg::DV_DONE;
				end
				mmfc_pkg::DV_DONE:
				begin
					div_st <= mmfc_pkg::DV_IDLE;
				end
				default: div_st <= mmfc_pkg::DV_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Event and quadrature accumulator
	assign evt_chg = rise && !clr_req && ((mode_r == mmfc_pkg::MD_QUAD) ||
		((mode_r == mmfc_pkg::MD_EVENT) && (evt_cnt_r < mmfc_pkg::EVENT_MAX)));

	always_ff @(posedge mclk)
	begin
		if (rst || clr_req)
		begin
			evt_cnt_r <= 32'h00000000; // R11
			dir_r <= 1'b0;
		end
		else if (evt_chg && (mode_r == mmfc_pkg::MD_QUAD))
		begin
			dir_r <= ~ev.lvl[1]; // R10
			evt_cnt_r <= ev.lvl[1] ? evt_cnt_r - 32'h00000001 : evt_cnt_r + 32'h00000001; // R10
		end
		else if (evt_chg)
			evt_cnt_r <= evt_cnt_r + 32'h00000001; // R08
	end

	// ==========================================================
	// Published result and its flags; a new result wins over a clearing read
	always_ff @(posedge mclk)
	begin
		if (rst || clr_req)
		begin
			result_r <= 32'h00000000;
			range_r <= 1'b0;
		end
		else if (pub_direct)
		begin
			result_r <= pub_val;
			range_r <= pub_range;
		end
		else if (div_st == mmfc_pkg::DV_DONE)
		begin
			result_r <= div_sat; // R03
			range_r <= 1'b0;
		end
	end

	// New-result flag, cleared by reading the result register.
	always_ff @(posedge mclk)
	begin
		if (rst)
			new_r <= 1'b0;
		else if (pub_direct || evt_chg || (div_st == mmfc_pkg::DV_DONE))
			new_r <= 1'b1;
		else if (xfer && !pwrite && (paddr == mmfc_pkg::OFS_RESULT))
			new_r <= 1'b0;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_count_cleared: assert property (clr_req |=> (evt_cnt_r == 32'h00000000) && (result_r == 32'h00000000)) // R11
		else $error("Count not cleared after mode write or reset command.");
	a_no_edge_stable: assert property (!rise && !clr_req |=> $stable(evt_cnt_r)) // R01
		else $error("Count changed without a crossing edge.");
	a_event_limit: assert property ((mode_r == mmfc_pkg::MD_EVENT) |-> (evt_cnt_r <= mmfc_pkg::EVENT_MAX)) // R08
		else $error("Event count passed its upper limit.");
	a_approx_span: assert property ((span_r > mmfc_pkg::APPROX_SPAN) [*2] |-> approx_r) // R09
		else $error("Large span not marked approximate.");
	a_quad_step: assert property ((mode_r == mmfc_pkg::MD_QUAD) && rise && !clr_req |=>
		(evt_cnt_r == ($past(ev.lvl[1]) ? $past(evt_cnt_r) - 32'h00000001 : $past(evt_cnt_r) + 32'h00000001))) // R10
		else $error("Quadrature step in the wrong direction.");
	a_width_pub: assert property ((mode_r == mmfc_pkg::MD_WIDTH) && fall && armed_r && !clr_req |=>
		(result_r == $past(hi_us_r)) && new_r) // R06
		else $error("Pulse width not published at the falling edge.");
	a_period_pub: assert property ((mode_r == mmfc_pkg::MD_PERIOD) && rise && armed_r && !clr_req |=>
		(result_r == $past(per_us_r))) // R07
		else $error("Period not published at the rising edge.");
	a_wait_bound: assert property (armed_r && ((mode_r == mmfc_pkg::MD_FREQ_CYC) || (mode_r == mmfc_pkg::MD_DUTY)) |->
		(per_cyc_r <= LATENCY_MAX_CYC)) // R04
		else $error("Cycle measurement waited past its latency limit.");
	a_div_finish: assert property (disable iff (rst || clr_req) div_st == mmfc_pkg::DV_RUN |-> // R03
		##[1:48] (div_st == mmfc_pkg::DV_DONE))
		else $error("Divider did not finish in time.");
	a_gate_start: assert property (gate_end && (div_st == mmfc_pkg::DV_IDLE) && !clr_req |=> div_st == mmfc_pkg::DV_RUN) // R02
		else $error("Gate end did not start the frequency division.");
	a_duty_pct: assert property ((mode_r == mmfc_pkg::MD_DUTY) && (div_st == mmfc_pkg::DV_DONE) && !clr_req |=>
		(result_r <= 32'h00000064)) // R05
		else $error("Duty result above one hundred percent.");

endmodule

`default_nettype wire

// file: dv/mmfc_cross_src.sv
// Purpose: Model of the analog input module's two threshold-crossing outputs.
// Assumes: Controls change just after rising mclk edges.
// Notes: Channel 0 stands low outside bursts; channel 1 is a steady direction level.
`default_nettype none

module mmfc_cross_src (
	// Clock
	input wire logic mclk,
	// Burst control
	input wire logic run,
	input wire logic [15:0] high_cyc,
	input wire logic [15:0] low_cyc,
	input wire logic dir_lvl,
	// Crossing outputs
	output logic [1:0] cross_in = 2'b00
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [15:0] ph_r = 16'h0000;

	// Each burst period starts low and crosses upward after low_cyc cycles.
	always_ff @(posedge mclk)
	begin
		if (!run)
		begin
			ph_r <= 16'h0000;
			cross_in[0] <= 1'b0;
		end
		else
		begin
			ph_r <= (ph_r == high_cyc + low_cyc - 16'h0001) ? 16'h0000 : ph_r + 16'h0001;
			cross_in[0] <= (ph_r >= low_cyc);
		end
	end

	// The direction channel is only a level sampled at counted rises.
	always_ff @(posedge mclk)
	begin
		cross_in[1] <= dir_lvl;
	end
endmodule

`default_nettype wire

// file: dv/test_multi_mode_frequency_counter.sv
// Purpose: Self-checking bench of the multi-mode counter through its APB registers.
// Assumes: 100 MHz mclk; short cycle-mode timeout set by parameter.
// Notes: Microsecond results are allowed one tick of slack, the tick being free-running.
`default_nettype none

module test_multi_mode_frequency_counter;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned LAT = 2000;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] cross_in;
	logic run = 1'b0;
	logic [15:0] high_cyc = 16'h0014;
	logic [15:0] low_cyc = 16'h0014;
	logic dir_lvl = 1'b0;
	int miscompares = 0;
	int n_tests = 0;

	// Free-running system clock.
	always #5 mclk = ~mclk;

	// Block under test and the input module model.
	mmfc_top #(.LATENCY_MAX_CYC(LAT)) dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cross_in(cross_in));
	mmfc_cross_src src (.mclk(mclk), .run(run), .high_cyc(high_cyc), .low_cyc(low_cyc),
		.dir_lvl(dir_lvl), .cross_in(cross_in));

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Compares against an exact value, or a range when lo and hi differ.
	task automatic chk(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
		logic ok;
		n_tests++;
		ok = (lo === hi) ? (got === lo) : ((^got !== 1'bx) && got >= lo && got <= hi);
		if (!ok)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
		begin
			miscompares++;
			$display("[FAIL] pready expected 1 seen 0");
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input string what, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		chk(what, lo, hi, r & m);
	endtask

	// Sends n whole periods on the counted channel, then stands still low.
	task automatic pulses(input int n, input logic [15:0] hi, input logic [15:0] lo);
		high_cyc <= hi;
		low_cyc <= lo;
		run <= 1'b1;
		repeat (n * (hi + lo)) @(posedge mclk);
		run <= 1'b0;
	endtask

	// Reset values, an unmapped address and a read-only result.
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rd(mmfc_pkg::OFS_CTRL, 32'hffffffff, "ctrl", 32'h0, 32'h0);
		rd(mmfc_pkg::OFS_GATE, 32'hffffffff, "gate", 32'h000186a0, 32'h000186a0);
		rd(mmfc_pkg::OFS_SPAN, 32'hffffffff, "span", 32'h00002710, 32'h00002710);
		rd(mmfc_pkg::OFS_STATUS, 32'hffffffff, "status", 32'h0, 32'h0);
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk("unmapped err", 32'h1, 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, 32'h0, r);
		wr(mmfc_pkg::OFS_RESULT, 32'h00000005);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "result ro", 32'h0, 32'h0);
	endtask

	// Event counting, the new flag, clearing by command and by reselection.
	task automatic t_event();
		wr(mmfc_pkg::OFS_CTRL, 32'h6);
		pulses(5, 16'h0014, 16'h0014);
		repeat (8) @(posedge mclk);
		rd(mmfc_pkg::OFS_STATUS, 32'h1, "new set", 32'h1, 32'h1);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "events", 32'h5, 32'h5);
		rd(mmfc_pkg::OFS_STATUS, 32'h1, "new clear", 32'h0, 32'h0);
		wr(mmfc_pkg::OFS_CMD, 32'h1);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "cmd clear", 32'h0, 32'h0);
		pulses(2, 16'h0014, 16'h0014);
		repeat (8) @(posedge mclk);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "events 2", 32'h2, 32'h2);
		wr(mmfc_pkg::OFS_CTRL, 32'h6);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "reselect", 32'h0, 32'h0);
	endtask

	// Approximate flag at the span boundary.
	task automatic t_approx();
		wr(mmfc_pkg::OFS_SPAN, 32'h0000ea60);
		rd(mmfc_pkg::OFS_STATUS, 32'h2, "approx 60000", 32'h0, 32'h0);
		wr(mmfc_pkg::OFS_SPAN, 32'h0000ea61);
		rd(mmfc_pkg::OFS_STATUS, 32'h2, "approx 60001", 32'h2, 32'h2);
		wr(mmfc_pkg::OFS_SPAN, 32'h00002710);
	endtask

	// Timed modes on a 2 us high, 5 us period train, then the cycle-mode timeout.
	task automatic t_timed();
		logic [2:0] md [4] = '{3'h5, 3'h4, 3'h3, 3'h2};
		logic [31:0] lo [4] = '{32'h4, 32'h1, 32'h28, 32'h00030d40};
		logic [31:0] hi [4] = '{32'h6, 32'h3, 32'h28, 32'h00030d40};
		for (int k = 0; k < 4; k++)
		begin
			wr(mmfc_pkg::OFS_CTRL, {29'h0, md[k]});
			pulses(3, 16'h00c8, 16'h012c);
			repeat (60) @(posedge mclk);
			rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "timed result", lo[k], hi[k]);
		end
		repeat (LAT + 100) @(posedge mclk);
		rd(mmfc_pkg::OFS_STATUS, 32'h8, "range", 32'h8, 32'h8);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "timeout result", 32'h0, 32'h0);
	endtask

	// Gated frequency over a 10 us gate with a 1 MHz train.
	task automatic t_gate();
		wr(mmfc_pkg::OFS_GATE, 32'h0000000a);
		wr(mmfc_pkg::OFS_CTRL, 32'h1);
		pulses(30, 16'h0032, 16'h0032);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "gated", 32'h000dbba0, 32'h0010c8e0);
	endtask

	// Quadrature counts up with direction low, down with it high.
	task automatic t_quad();
		wr(mmfc_pkg::OFS_CTRL, 32'h7);
		pulses(3, 16'h0014, 16'h0014);
		dir_lvl <= 1'b1;
		repeat (10) @(posedge mclk);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "quad up", 32'h3, 32'h3);
		rd(mmfc_pkg::OFS_STATUS, 32'h4, "dir up", 32'h4, 32'h4);
		pulses(5, 16'h0014, 16'h0014);
		repeat (10) @(posedge mclk);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "quad down", 32'hfffffffe, 32'hfffffffe);
		rd(mmfc_pkg::OFS_STATUS, 32'h4, "dir down", 32'h0, 32'h0);
		wr(mmfc_pkg::OFS_CMD, 32'h1);
		rd(mmfc_pkg::OFS_RESULT, 32'hffffffff, "quad clear", 32'h0, 32'h0);
	endtask

	// Main sequence.
	initial
	begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_event();
		t_approx();
		t_timed();
		t_gate();
		t_quad();
		summarize();
	end
endmodule

`default_nettype wire
